// File: bench/poscmp_core_tb.sv
// Self-checking bench for the position comparator.
`timescale 1ns/100ps
module poscmp_core_tb;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic meas_a_i = 1'b0;
	logic meas_b_i = 1'b0;
	logic ext_reset_n_i = 1'b1;
	logic ext_sample_n_i = 1'b1;
	logic ext_fnull_n_i = 1'b1;
	logic ext_fzs_n_i = 1'b1;
	logic sig_err_i = 1'b1;
	logic dec_point_i = 1'b1;
	logic other_busy = 1'b1;
	logic mode_quad = 1'b0;
	logic [1:0] rd_lane = 2'h0;
	logic wr, rst, smp, sn_oe, sn, nn, nl, zs;
	logic [1:0] wid, lane;
	logic [15:0] wd, rd;
	logic [31:0] rb;
	logic [27:0] dn;
	logic [23:0] hoe;
	int checks = 0;
	int fail_count = 0;
	poscmp_ctl_model ctl_inst (.clk_i(sys_clk_i), .wr_o(wr), .width_o(wid),
		.lane_o(lane), .wdata_o(wd), .reset_o(rst), .sample_o(smp));
	poscmp_core poscmp_core_inst (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .mode_quad_i(mode_quad), .meas_a_i(meas_a_i),
		.meas_b_i(meas_b_i), .ext_reset_n_i(ext_reset_n_i),
		.ext_sample_n_i(ext_sample_n_i), .ext_fnull_n_i(ext_fnull_n_i),
		.ext_fzs_n_i(ext_fzs_n_i), .ctl_wr_i(wr), .ctl_width_i(wid),
		.ctl_lane_i(lane), .ctl_wdata_i(wd), .ctl_rd_lane_i(rd_lane),
		.ctl_reset_i(rst), .ctl_sample_i(smp), .ctl_broadcast_i(1'b0),
		.zs_ms_i(8'h01), .sig_err_i(sig_err_i), .dec_point_i(dec_point_i),
		.ctl_rdata_o(rd), .readback_o(rb),
		.sys_null_line_i(~(sn_oe | other_busy)), .sys_null_oe_o(sn_oe),
		.sys_null_o(sn), .diff_n_o(dn), .diff_hi_oe_o(hoe), .null_n_o(nn),
		.null_o(nl), .zero_speed_o(zs));
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	task automatic report_and_stop;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Negative-true sign-magnitude image of a difference
	function automatic logic [27:0] dexp(input int d);
		return ~{d < 0, 27'(d < 0 ? -d : d)};
	endfunction
	// Covers the input synchroniser and compare pipeline
	task automatic settle;
		repeat (8) @(negedge sys_clk_i);
	endtask
	task automatic cnt(input logic dn_sel, input int n);
		repeat (n) begin
			@(negedge sys_clk_i);
			meas_a_i = ~dn_sel;
			meas_b_i = dn_sel;
			repeat (2) @(negedge sys_clk_i);
			meas_a_i = 1'b0;
			meas_b_i = 1'b0;
			@(negedge sys_clk_i);
		end
		settle();
	endtask
	// One quadrature state, held well past the synchroniser
	task automatic qstep(input logic a, input logic b);
		@(negedge sys_clk_i);
		meas_a_i = a;
		meas_b_i = b;
		repeat (3) @(negedge sys_clk_i);
	endtask
	task automatic samp;
		ctl_inst.cmd(1'b0);
		settle();
	endtask
	initial begin
		repeat (80000) @(posedge sys_clk_i);
		fail_count++;
		report_and_stop();
	end
	initial begin
		int k;
		repeat (3) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		settle();
		chk(dn, 28'hFFF_FFFF);
		samp();
		chk(rb[27:0], 28'h000_00A0);
		chk(rd, 16'h00A0);
		rd_lane = 2'h1;
		@(negedge sys_clk_i);
		chk(rd, 16'h9000);
		ctl_inst.load16({4'h5, 28'h000_00C8});
		settle();
		chk(dn, 28'hFFF_FFFF);
		samp();
		chk(dn, dexp(40));
		chk(hoe, 24'h00_0002);
		chk(nn, 1'b1);
		cnt(1'b0, 36);
		samp();
		chk(rb[27:0], 28'h000_00C4);
		chk(dn, dexp(4));
		chk({nn, nl}, 2'h1);
		other_busy = 1'b0;
		settle();
		chk(sn, 1'b1);
		chk(rb[31:28], 4'hB);
		other_busy = 1'b1;
		settle();
		chk(sn, 1'b0);
		ctl_inst.load8({4'h3, 28'h000_00BE});
		settle();
		chk(dn, 28'hFFF_FFFF);
		samp();
		chk(dn, dexp(-6));
		chk(nn, 1'b1);
		rd_lane = 2'h0;
		@(negedge sys_clk_i);
		chk(rd, 16'h00C4);
		sig_err_i = 1'b0;
		rd_lane = 2'h3;
		@(negedge sys_clk_i);
		chk(rd, 16'h0010);
		cnt(1'b1, 3);
		chk(dn, dexp(-3));
		chk(nn, 1'b0);
		ext_fnull_n_i = 1'b0;
		settle();
		chk(dn, 28'hFFF_FFFF);
		ext_fnull_n_i = 1'b1;
		settle();
		chk(dn, dexp(-3));
		chk(zs, 1'b0);
		k = 0;
		while (zs !== 1'b1 && k < 52000) begin
			@(negedge sys_clk_i);
			k++;
		end
		chk(k > 49900 && k < 51000, 1'b1);
		cnt(1'b0, 1);
		chk(zs, 1'b0);
		ext_fzs_n_i = 1'b0;
		settle();
		chk(zs, 1'b1);
		ext_fzs_n_i = 1'b1;
		settle();
		chk(zs, 1'b1);
		ext_reset_n_i = 1'b0;
		cnt(1'b0, 2);
		ext_reset_n_i = 1'b1;
		settle();
		cnt(1'b0, 5);
		ext_sample_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		ext_sample_n_i = 1'b1;
		settle();
		chk(rb[27:0], 28'h000_00A5);
		ctl_inst.cmd(1'b1);
		settle();
		chk(dn, 28'hFFF_FFFF);
		samp();
		chk(rb[27:0], 28'h000_00A0);
		mode_quad = 1'b1;
		qstep(1'b1, 1'b0);
		qstep(1'b1, 1'b1);
		qstep(1'b0, 1'b1);
		qstep(1'b0, 1'b0);
		qstep(1'b0, 1'b1);
		qstep(1'b1, 1'b1);
		settle();
		samp();
		chk(rb[27:0], 28'h000_00A2);
		chk(dn, dexp(28));
		report_and_stop();
	end
endmodule

// File: bench/poscmp_ctl_model.sv
// Controller model that loads targets and issues commands.
`timescale 1ns/100ps
module poscmp_ctl_model (
	// Clock
	input wire logic clk_i,
	// Command outputs
	output logic wr_o,
	output logic [1:0] width_o,
	output logic [1:0] lane_o,
	output logic [15:0] wdata_o,
	output logic reset_o,
	output logic sample_o
);
	initial begin
		wr_o = 1'b0;
		width_o = poscmp_pkg::WIDTH_16;
		lane_o = 2'h0;
		wdata_o = 16'h0000;
		reset_o = 1'b0;
		sample_o = 1'b0;
	end
	task automatic put(input logic [1:0] w, input logic [1:0] l,
		input logic [15:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		width_o = w;
		lane_o = l;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		// Released data must not look valid
		wdata_o = ~d;
	endtask
	task automatic load16(input logic [31:0] t);
		put(poscmp_pkg::WIDTH_16, 2'h0, t[15:0]);
		put(poscmp_pkg::WIDTH_16, 2'h1, t[31:16]);
	endtask
	task automatic load8(input logic [31:0] t);
		for (int i = 0; i < 4; i++) begin
			put(poscmp_pkg::WIDTH_8, 2'(i), {8'h00, t[8*i +: 8]});
		end
	endtask
	// One-cycle command pulse: 1 resets, 0 samples
	task automatic cmd(input logic rst);
		@(negedge clk_i);
		reset_o = rst;
		sample_o = ~rst;
		@(negedge clk_i);
		reset_o = 1'b0;
		sample_o = 1'b0;
	endtask
endmodule

// File: hw/poscmp_core.sv
// Closed-loop position comparator: counter, compare, null and zero speed.
//
// Overview of operation
// [RULE1] Count up/down pulses or quadrature pairs, pulses down to 50 ns.
// [RULE2] Assemble 32-bit target from two 16-bit or four 8-bit writes.
// [RULE3] Loading a new target forces the difference output to zero.
// [RULE4] Difference is 28-bit sign-magnitude, driven negative-true.
// [RULE5] Upper 24 difference bits are open-drain for wired-OR.
// [RULE6] Null when counter is within tolerance of destination.
// [RULE7] Null given as active-low pin and as readable status.
// [RULE8] System null high only while every comparator is nulled.
// [RULE9] Zero speed high after no count for the programmed interval.
// [RULE10] Reset loads counter with 160 and forces null.
// [RULE11] External reset is active low, held while low.
// [RULE12] Controller reset addressed to this unit or broadcast.
// [RULE13] Sample copies counter into holding latches for readback.
// [RULE14] Sample after target load releases the forced null.
// [RULE15] External sample pulse is low for at least 40 ns.
// [RULE16] Controller sample addressed to this unit or broadcast.
// [RULE17] External forced null zeroes difference and drives null low.
// [RULE18] Forced zero speed holds output high, then one timeout more; the code keeps it high after release until the next count.
// [RULE19] Readback is counter plus four status bits, 16 or 8 bit parts.
// [RULE20] Difference is destination minus counter, updated every clock.
// [RULE21] Asynchronous control inputs are synchronised before use.
`timescale 1ns/100ps
module poscmp_core #(
	parameter int ZS_TIMEOUT = poscmp_pkg::ZS_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Measurement inputs
	input wire logic mode_quad_i,
	input wire logic meas_a_i,
	input wire logic meas_b_i,
	// External controls, active low
	input wire logic ext_reset_n_i,
	input wire logic ext_sample_n_i,
	input wire logic ext_fnull_n_i,
	input wire logic ext_fzs_n_i,
	// Controller interface
	input wire logic ctl_wr_i,
	input wire logic [1:0] ctl_width_i,
	input wire logic [1:0] ctl_lane_i,
	input wire logic [15:0] ctl_wdata_i,
	input wire logic [1:0] ctl_rd_lane_i,
	input wire logic ctl_reset_i,
	input wire logic ctl_sample_i,
	input wire logic ctl_broadcast_i,
	input wire logic [7:0] zs_ms_i,
	input wire logic sig_err_i,
	input wire logic dec_point_i,
	output logic [15:0] ctl_rdata_o,
	output logic [31:0] readback_o,
	// System null wired line
	input wire logic sys_null_line_i,
	output logic sys_null_oe_o,
	output logic sys_null_o,
	// Results
	output logic [27:0] diff_n_o,
	output logic [23:0] diff_hi_oe_o,
	output logic null_n_o,
	output logic null_o,
	output logic zero_speed_o
);
	localparam int W = poscmp_pkg::CNT_W;
	// Three-stage synchronisers; change accepted once stages 2 and 3 agree
	logic [5:0] s1_q, s2_q, s3_q, flt_q;
	logic [5:0] s1_d, s2_d, s3_d;
	logic [5:0] raw;
	always_comb begin
		raw = {sys_null_line_i, ext_fzs_n_i, ext_fnull_n_i,
			ext_sample_n_i, meas_b_i, meas_a_i};
		s1_d = raw;
		s2_d = s2_q;
		s3_d = s3_q;
		s2_d = s1_q;
		s3_d = s2_q;
	end
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_flt
			always_ff @(posedge sys_clk_i) begin
				if (!reset_n_i) begin
					// Idle levels: measurement pins low, controls high,
					// so no false quadrature step follows reset
					flt_q[gi] <= (gi > 1) ? 1'b1 : 1'b0;
				end else if (s2_q[gi] == s3_q[gi]) begin
					flt_q[gi] <= s3_q[gi]; // see [RULE21]
				end
			end
		end
	endgenerate
	always_ff @(posedge sys_clk_i) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
		s3_q <= s3_d;
	end
	// External reset passes the same three stages
	logic [2:0] rs_q, rs_d;
	logic ext_rst_q, ext_rst_d;
	always_comb begin
		rs_d = {rs_q[1:0], ext_reset_n_i};
		ext_rst_d = ext_rst_q;
		if (rs_q[1] == rs_q[2]) begin
			ext_rst_d = !rs_q[2]; // see [RULE21]
		end
	end
	always_ff @(posedge sys_clk_i) begin
		rs_q <= rs_d;
		if (!reset_n_i) begin
			ext_rst_q <= 1'b0;
		end else begin
			ext_rst_q <= ext_rst_d;
		end
	end
	// Broadcast and addressed commands behave identically at this end
	logic do_reset, do_sample;
	assign do_reset = ext_rst_q || ctl_reset_i; // see [RULE11] see [RULE12]
	logic a_q, b_q, smp_q;
	logic [27:0] cnt_q, cnt_d, hold_q, hold_d, dest_q, dest_d;
	logic [3:0] tol_q, tol_d;
	logic force_q, force_d, ovf_q, ovf_d, cnt_ev;
	always_ff @(posedge sys_clk_i) begin
		a_q <= flt_q[0];
		b_q <= flt_q[1];
		smp_q <= flt_q[2];
	end
	assign do_sample = ctl_sample_i || (smp_q && !flt_q[2]); // see [RULE16]
	logic up, dn;
	always_comb begin
		up = 1'b0;
		dn = 1'b0;
		if (mode_quad_i) begin
			if ((flt_q[0] != a_q) || (flt_q[1] != b_q)) begin
				// Forward when new A differs from old B
				up = (flt_q[0] ^ b_q) && (flt_q[0] != a_q);
				up = up || (!(flt_q[1] ^ a_q) && (flt_q[1] != b_q));
				dn = !up;
			end
		end else begin
			up = flt_q[0] && !a_q; // see [RULE1]
			dn = flt_q[1] && !b_q;
		end
	end
	assign cnt_ev = up ^ dn;
	always_comb begin
		cnt_d = cnt_q;
		ovf_d = ovf_q;
		hold_d = hold_q;
		dest_d = dest_q;
		tol_d = tol_q;
		force_d = force_q;
		if (up && !dn) begin
			cnt_d = cnt_q + 28'h000_0001;
			ovf_d = ovf_q || (cnt_q == 28'hFFF_FFFF);
		end else if (dn && !up) begin
			cnt_d = cnt_q - 28'h000_0001;
			ovf_d = ovf_q || (cnt_q == 28'h000_0000);
		end
		if (do_sample) begin
			hold_d = cnt_q; // see [RULE13]
			force_d = 1'b0; // see [RULE14]
		end
		if (ctl_wr_i) begin
			if (ctl_width_i == poscmp_pkg::WIDTH_16) begin
				if (ctl_lane_i[0]) begin
					{tol_d, dest_d[27:16]} = ctl_wdata_i; // see [RULE2]
				end else begin
					dest_d[15:0] = ctl_wdata_i;
				end
			end else begin
				unique case (ctl_lane_i)
					2'd0: dest_d[7:0] = ctl_wdata_i[7:0];
					2'd1: dest_d[15:8] = ctl_wdata_i[7:0];
					2'd2: dest_d[23:16] = ctl_wdata_i[7:0];
					2'd3: {tol_d, dest_d[27:24]} = ctl_wdata_i[7:0];
				endcase
			end
			force_d = 1'b1; // see [RULE3]
		end
		if (do_reset) begin
			cnt_d = poscmp_pkg::CNT_RESET_VAL; // see [RULE10]
			ovf_d = 1'b0;
			force_d = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cnt_q <= poscmp_pkg::CNT_RESET_VAL;
			ovf_q <= 1'b0;
			hold_q <= 28'h000_0000;
			dest_q <= 28'h000_0000;
			tol_q <= 4'h0;
			force_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			hold_q <= hold_d;
			dest_q <= dest_d;
			tol_q <= tol_d;
			force_q <= force_d;
		end
	end
	// Difference and null, registered
	logic [W:0] diff_w;
	logic [27:0] mag, diffn_d;
	logic sign, near, fn, nul_d;
	always_comb begin
		diff_w = {1'b0, dest_q} - {1'b0, cnt_q}; // see [RULE20]
		sign = dest_q < cnt_q;
		mag = sign ? (cnt_q - dest_q) : diff_w[27:0];
		near = mag <= {24'h00_0000, tol_q}; // see [RULE6]
		fn = force_q || !flt_q[3];
		// Bit 27 is the sign; negative-true so one drives low
		diffn_d = fn ? 28'hFFF_FFFF : ~{sign, mag[26:0]}; // see [RULE4]
		nul_d = near && flt_q[3]; // see [RULE17]
	end
	logic nul_q;
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			diff_n_o <= 28'hFFF_FFFF;
			nul_q <= 1'b0;
		end else begin
			diff_n_o <= diffn_d;
			nul_q <= nul_d;
		end
	end
	// Open drain: enable only when driving a logic one (low level)
	assign diff_hi_oe_o = ~diff_n_o[27:4]; // see [RULE5]
	assign null_n_o = !nul_q; // see [RULE7]
	assign null_o = nul_q;
	// Wired-AND system null: pull low while not nulled
	assign sys_null_oe_o = !nul_q; // see [RULE8]
	assign sys_null_o = flt_q[5];
	// Zero speed timer in millisecond ticks
	localparam int MS_CYC = poscmp_pkg::CLK_HZ / 1000;
	logic [15:0] tick_q, tick_d;
	logic [7:0] ms_q, ms_d;
	logic zs_q, zs_d;
	logic [7:0] lim;
	always_comb begin
		lim = zs_ms_i;
		if (lim < 8'(poscmp_pkg::ZS_MIN_MS)) lim = 8'(poscmp_pkg::ZS_MIN_MS);
		if (lim > 8'(poscmp_pkg::ZS_MAX_MS)) lim = 8'(poscmp_pkg::ZS_MAX_MS);
		tick_d = tick_q + 16'h0001;
		ms_d = ms_q;
		zs_d = zs_q;
		if (tick_q == 16'(MS_CYC - 1)) begin
			tick_d = 16'h0000;
			if (ms_q >= lim - 8'h01) begin
				zs_d = 1'b1; // see [RULE9]
			end else begin
				ms_d = ms_q + 8'h01;
			end
		end
		if (cnt_ev || !flt_q[4]) begin
			tick_d = 16'h0000;
			ms_d = 8'h00;
			zs_d = !flt_q[4]; // see [RULE18]
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			tick_q <= 16'h0000;
			ms_q <= 8'h00;
			zs_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
			ms_q <= ms_d;
			zs_q <= zs_d;
		end
	end
	assign zero_speed_o = zs_q;
	// Readback word
	always_comb begin
		readback_o = {sig_err_i, ovf_q, flt_q[5], dec_point_i, hold_q};
		ctl_rdata_o = ctl_rd_lane_i[0] ? readback_o[31:16] : readback_o[15:0];
		if (ctl_width_i == poscmp_pkg::WIDTH_8) begin // see [RULE19]
			ctl_rdata_o = {8'h00, readback_o[8*ctl_rd_lane_i +: 8]};
		end
	end
	// Checks
	a_rst_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ctl_reset_i |=> cnt_q == poscmp_pkg::CNT_RESET_VAL && force_q) // see [RULE10]
		else $error("reset did not load counter");
	a_wr_force: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ctl_wr_i |=> ##1 diff_n_o == 28'hFFF_FFFF) // see [RULE3]
		else $error("target load did not force null");
	a_smp_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ctl_sample_i && !do_reset |=> hold_q == $past(cnt_q)) // see [RULE13]
		else $error("sample missed counter");
	a_null_pin: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		!flt_q[3] |=> null_n_o) // see [RULE17]
		else $error("forced null left null asserted");
	a_fzs_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		!flt_q[4] |=> zero_speed_o) // see [RULE18]
		else $error("forced zero speed not high");
	a_move_clr: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		cnt_ev && flt_q[4] |=> !zero_speed_o) // see [RULE9]
		else $error("count did not clear zero speed");
	a_sys_null: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		$past(!near || !flt_q[3]) |-> sys_null_oe_o) // see [RULE8]
		else $error("system line released while not nulled");
	a_smp_rel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ctl_sample_i && !ctl_wr_i && !do_reset |=> !force_q) // see [RULE14]
		else $error("sample did not release force");
endmodule

// File: hw/poscmp_pkg.sv
// Constants shared by the position comparator.
package poscmp_pkg;
	localparam int CNT_W = 28;
	localparam int TOL_W = 4;
	localparam logic [27:0] CNT_RESET_VAL = 28'h000_00A0;
	localparam int CLK_HZ = 50_000_000;
	localparam int ZS_NOMINAL_MS = 17;
	localparam int ZS_CYCLES = CLK_HZ / 1000 * ZS_NOMINAL_MS;
	localparam int ZS_MIN_MS = 1;
	localparam int ZS_MAX_MS = 100;
	localparam int SAMPLE_MIN_NS = 40;
	localparam int PULSE_MIN_NS = 50;
	localparam int STAT_SIGERR_BIT = 31;
	localparam int STAT_OVFL_BIT = 30;
	localparam int STAT_SYSNULL_BIT = 29;
	localparam int STAT_DP_BIT = 28;
	// Width select codes for the target and readback word
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_8 = 2'h1;
	typedef enum logic [1:0] {
		POSCMP_IN_UPDN = 2'b00,
		POSCMP_IN_QUAD = 2'b01
	} poscmp_mode_t;
endpackage
